// [src/cpc_pkg.sv]
// Package for the codec port control bits block: register map, field layout, carriers.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
package cpc_pkg;

	// ************************************************
	// Register map
	// ************************************************
	localparam logic [3:0] CPC_OFF_CTRL   = 4'h0;
	localparam logic [3:0] CPC_OFF_TXDATA = 4'h4;
	localparam logic [3:0] CPC_OFF_STATUS = 4'h8;
	localparam logic [3:0] CPC_OFF_MASK   = 4'hC;

	// ************************************************
	// Control register fields
	// ************************************************
	localparam int CPC_BIT_RESET_CTRL = 0;
	localparam int CPC_BIT_SEL_LO     = 1;
	localparam int CPC_BIT_SEL_HI     = 2;
	localparam int CPC_BIT_TX_EMPTY   = 5;
	localparam int CPC_BIT_TX_IRQ_EN  = 4;
	localparam logic [7:0]  CPC_CTRL_RESET   = 8'h00;
	localparam logic [1:0]  CPC_SEL_PRIMARY  = 2'h0;
	localparam logic [1:0]  CPC_IRQ_RESET    = 2'h0;
	localparam logic [31:0] CPC_UNMAPPED_VAL = 32'h00000000;

	// Interrupt status and mask bit positions
	localparam int CPC_IRQ_TX_EMPTY = 0;
	localparam int CPC_IRQ_SENT     = 1;

	// Control fields as seen by the serial side
	typedef struct packed {
		logic       txIrqEnable;
		logic [1:0] codecSelect;
		logic       codecResetCtrl;
	} cpc_ctrl_t;

	// Transmit hand-off to the serial engine
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       secondary;
	} cpc_tx_t;

endpackage

// [src/cpc_tx_hold.sv]
// Transmit holding register with its empty flag.
// Assumes the serial engine pulses txDone once the held byte has gone out.
`timescale 1ns/1ps
module cpc_tx_hold
	import cpc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Load from the register side
	input  wire logic       load,
	input  wire logic [7:0] loadData,
	input  wire logic       loadSecondary,
	// Serial engine side
	input  wire logic       txDone,
	output cpc_tx_t         tx,
	output logic            emptyFlag
);
	cpc_tx_t txReg;
	logic    emptyReg;
	cpc_tx_t txNext;
	logic    emptyNext;

	// Load wins over completion: the new byte is what now stands waiting
	assign emptyNext = load ? 1'b0 : (txDone ? 1'b1 : emptyReg);
	assign txNext    = load ? '{valid: 1'b1, data: loadData, secondary: loadSecondary}
	                        : (txDone ? '{valid: 1'b0, data: txReg.data,
	                                      secondary: txReg.secondary} : txReg);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txReg    <= '{valid: 1'b0, data: 8'h00, secondary: 1'b0};
			emptyReg <= 1'b1;
		end else begin
			txReg    <= txNext;
			emptyReg <= emptyNext;
		end
	end

	assign tx        = txReg;
	assign emptyFlag = emptyReg;
endmodule

// [src/cpc_ctrl.sv]
// Codec port control bits: reset output, codec select, transmit interrupt.
// Assumes an Avalon-MM master on clk and a serial engine that reports txDone.
`timescale 1ns/1ps
module cpc_ctrl
	import cpc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// Serial engine
	input  wire logic        txDone,
	input  wire logic        i2sMode,
	output logic             txValid,
	output logic [7:0]       txData,
	output logic             txSecondary,
	// Codec pins and interrupt
	output logic             codecResetOutN,
	output logic             irq
);
	// ************************************************
	// Declarations
	// ************************************************
	// Bus handshake
	logic        waitReq_reg;
	logic        access;
	logic        wrStb;
	logic        rdStb;
	// Address decode
	logic        hitCtrl;
	logic        hitTx;
	logic        hitStatus;
	logic        hitMask;
	logic        loadTx;
	// Control register
	logic [7:0]  ctrlBits_reg;
	logic [7:0]  ctrlBits_next;
	logic [7:0]  ctrlView;
	logic [1:0]  selWrite;
	logic [1:0]  codecSel;
	logic        isSecond;
	logic        resetCtrl;
	// Read path
	logic [31:0] readMux;
	logic [31:0] readdata_reg;
	logic [31:0] readdata_next;
	// Interrupt status and mask
	logic [1:0]  irqStatus_reg;
	logic [1:0]  irqStatus_next;
	logic [1:0]  irqMask_reg;
	logic [1:0]  irqMask_next;
	logic [1:0]  events;
	logic [1:0]  clearBits;
	logic        emptyRise;
	logic        txEmpty_reg;
	// Transmit path
	cpc_tx_t     txHold;
	logic        txEmpty;
	logic        secondary_reg;
	logic        secondary_next;
	// Output flops
	logic        resetOut_reg;
	logic        irq_reg;
	logic        irq_next;

	// ************************************************
	// Functions
	// ************************************************
	// All four address bits compared, so no offset aliases another
	function automatic logic regHit(input logic [3:0] addr, input logic [3:0] offset);
		regHit = (addr == offset);
	endfunction

	// ************************************************
	// Bus handshake
	// ************************************************
	// One wait cycle; the acknowledge cycle is never taken as a new request
	assign access = (read | write) & waitReq_reg;
	assign wrStb  = write & access & byteenable[0];
	assign rdStb  = read & access;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			waitReq_reg <= 1'b1;
		end else begin
			waitReq_reg <= ~access;
		end
	end

	// ************************************************
	// Address decode
	// ************************************************
	assign hitCtrl   = regHit(address, CPC_OFF_CTRL);
	assign hitTx     = regHit(address, CPC_OFF_TXDATA);
	assign hitStatus = regHit(address, CPC_OFF_STATUS);
	assign hitMask   = regHit(address, CPC_OFF_MASK);
	assign loadTx    = wrStb & hitTx;

	// ************************************************
	// Control register
	// ************************************************
	assign selWrite = writedata[CPC_BIT_SEL_HI:CPC_BIT_SEL_LO];

	// Reserved and read-only positions are never stored; reserved ones read 0, and bit 5 reads the empty flag
	always_comb begin
		ctrlBits_next = ctrlBits_reg;
		if (wrStb & hitCtrl) begin
			ctrlBits_next                                = CPC_CTRL_RESET;
			ctrlBits_next[CPC_BIT_RESET_CTRL]            = writedata[CPC_BIT_RESET_CTRL];
			ctrlBits_next[CPC_BIT_SEL_HI:CPC_BIT_SEL_LO] = selWrite;
			ctrlBits_next[CPC_BIT_TX_IRQ_EN]             = writedata[CPC_BIT_TX_IRQ_EN];
		end
	end

	assign codecSel  = ctrlBits_reg[CPC_BIT_SEL_HI:CPC_BIT_SEL_LO];
	assign isSecond  = codecSel != CPC_SEL_PRIMARY;
	assign resetCtrl = ctrlBits_reg[CPC_BIT_RESET_CTRL];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlBits_reg <= CPC_CTRL_RESET;
		end else begin
			ctrlBits_reg <= ctrlBits_next;
		end
	end

	// ************************************************
	// Read path
	// ************************************************
	always_comb begin
		ctrlView                   = ctrlBits_reg;
		ctrlView[CPC_BIT_TX_EMPTY] = txEmpty;
	end

	assign readMux = hitCtrl   ? {24'h000000, ctrlView} :
	                 hitStatus ? {30'h0, irqStatus_reg} :
	                 hitMask   ? {30'h0, irqMask_reg} :
	                 hitTx     ? {24'h000000, txHold.data} : CPC_UNMAPPED_VAL;

	// Read data stand until the next read, not only in the acknowledge cycle
	assign readdata_next = rdStb ? readMux : readdata_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata_reg <= CPC_UNMAPPED_VAL;
		end else begin
			readdata_reg <= readdata_next;
		end
	end

	// ************************************************
	// Interrupt status and mask
	// ************************************************
	// Empty event taken on the rising edge of the flag, so a holding
	// register that stays empty cannot raise the event twice
	assign emptyRise = txEmpty & ~txEmpty_reg;
	assign clearBits = (wrStb & hitStatus) ? writedata[1:0] : CPC_IRQ_RESET;

	always_comb begin
		events                   = CPC_IRQ_RESET;
		events[CPC_IRQ_TX_EMPTY] = emptyRise & ctrlBits_reg[CPC_BIT_TX_IRQ_EN];
		events[CPC_IRQ_SENT]     = txDone;
	end

	// A new event wins over a write-one-to-clear in the same cycle
	assign irqStatus_next = (irqStatus_reg & ~clearBits) | events;
	assign irqMask_next   = (wrStb & hitMask) ? writedata[1:0] : irqMask_reg;
	assign irq_next       = |(irqStatus_next & irqMask_next);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irqStatus_reg <= CPC_IRQ_RESET;
		end else begin
			irqStatus_reg <= irqStatus_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irqMask_reg <= CPC_IRQ_RESET;
		end else begin
			irqMask_reg <= irqMask_next;
		end
	end

	// Starts at the flag's reset level so no false edge follows reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txEmpty_reg <= 1'b1;
		end else begin
			txEmpty_reg <= txEmpty;
		end
	end

	// ************************************************
	// Transmit holding register
	// ************************************************
	cpc_tx_hold u_hold (
		.clk          (clk),
		.rst_b        (rst_b),
		.load         (loadTx),
		.loadData     (writedata[7:0]),
		.loadSecondary(isSecond),
		.txDone       (txDone),
		.tx           (txHold),
		.emptyFlag    (txEmpty)
	);

	// No secondary slot exists in I2S modes, so the target is forced primary
	assign secondary_next = (loadTx ? isSecond : txHold.secondary) & ~i2sMode;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			secondary_reg <= 1'b0;
		end else begin
			secondary_reg <= secondary_next;
		end
	end

	// ************************************************
	// Output flops
	// ************************************************
	// Reset output stays low until software sets the bit, and is
	// driven the same way in I2S modes where nothing listens to it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resetOut_reg <= 1'b0;
		end else begin
			resetOut_reg <= resetCtrl;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign waitrequest    = waitReq_reg;
	assign readdata       = readdata_reg;
	assign codecResetOutN = resetOut_reg;
	assign irq            = irq_reg;
	assign txValid        = txHold.valid;
	assign txData         = txHold.data;
	assign txSecondary    = secondary_reg;
endmodule

// [tb/cpc_ctrl_monitor.sv]
// Port assertions for cpc_ctrl.
// Assumes one clock domain; bound to every cpc_ctrl.
`timescale 1ns/1ps
module cpc_ctrl_monitor(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// Register bus
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	input wire logic [3:0]  address,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	// Serial side and pins
	input wire logic        txDone,
	input wire logic        i2sMode,
	input wire logic        txValid,
	input wire logic        txSecondary,
	input wire logic        codecResetOutN,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire ctlW = write && waitrequest && byteenable[0] && address == 4'h0;
	wire ev   = txDone || write;
	property p_wait; (read || write) && waitrequest |-> ##[1:2] !waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("no acknowledge");
	property p_init; $rose(rst_b) |-> !codecResetOutN; endproperty
	a_init: assert property (p_init) else $error("codec reset released at start");
	property p_set; ctlW && writedata[0] |-> ##[1:3] codecResetOutN; endproperty
	a_set: assert property (p_set) else $error("codec reset not released");
	property p_clr; ctlW && !writedata[0] |-> ##[1:3] !codecResetOutN; endproperty
	a_clr: assert property (p_clr) else $error("codec reset not held");
	property p_load;
		write && waitrequest && byteenable[0] && address == 4'h4 |-> ##[1:3] txValid;
	endproperty
	a_load: assert property (p_load) else $error("byte not held");
	property p_sent; txDone && txValid && !write |-> ##[1:2] !txValid; endproperty
	a_sent: assert property (p_sent) else $error("held byte not emptied");
	property p_i2s; i2sMode && $past(i2sMode) && txValid |-> !txSecondary; endproperty
	a_i2s: assert property (p_i2s) else $error("secondary in serial mode");
	property p_irq;
		$rose(irq) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3) || $past(ev, 4);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without cause");
	c_rel: cover property ($rose(codecResetOutN));
	c_irq: cover property ($rose(irq));
	c_sent: cover property (txDone && txValid);
endmodule
bind cpc_ctrl cpc_ctrl_monitor u_mon(.clk, .rst_b, .read, .write, .waitrequest, .txDone,
	.i2sMode, .txValid, .txSecondary, .codecResetOutN, .irq, .address, .writedata,
	.byteenable);

// [tb/cpc_codec_model.sv]
// Codec side: takes the held byte after dly cycles.
// Assumes txValid stays up until txDone is seen.
`timescale 1ns/1ps
module cpc_codec_model(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// Held byte hand-off
	input wire logic       txValid,
	input wire logic [3:0] dly,
	output logic           txDone
);
	logic [3:0] cnt;
	logic       sent;
	wire        due = txValid && !sent && cnt == dly;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 4'h0;
			sent <= 1'b0;
			txDone <= 1'b0;
		end else begin
			txDone <= due;
			sent <= txValid && (sent || due);
			cnt <= (txValid && !sent && !due) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// [tb/cpc_ctrl_test.sv]
// Self-checking bench for cpc_ctrl.
// Assumes the monitor binds itself and the codec model answers.
`timescale 1ns/1ps
module cpc_ctrl_test;
	import cpc_pkg::*;
	logic        clk = 0, rst_b = 0, read = 0, write = 0, i2sMode = 0, en;
	logic [3:0]  address = 4'h0, byteenable = 4'hF, dly = 4'h2;
	logic [31:0] writedata = 32'h0, expQ[$];
	logic [7:0]  d, txData;
	logic [31:0] readdata;
	logic        waitrequest, txValid, txSecondary, codecResetOutN, irq, txDone;
	int          failures = 0, cmp_count = 0;
	initial forever #10 clk = ~clk;
	cpc_ctrl DUT(.clk, .rst_b, .address, .read, .write, .writedata, .byteenable, .readdata,
		.waitrequest, .txDone, .i2sMode, .txValid, .txData, .txSecondary, .codecResetOutN, .irq);
	cpc_codec_model u_codec(.clk, .rst_b, .txValid, .dly, .txDone);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input logic rd, input logic [3:0] a, input logic [31:0] v);
		read <= rd; write <= !rd; address <= a; writedata <= v;
		do @(posedge clk); while (waitrequest);
		read <= 0; write <= 0;
		@(posedge clk);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1, a, 0);
	endtask
	task tally_and_finish;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk) if (read && !waitrequest) chk(readdata, expQ.pop_front());
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(92));
		repeat (8) @(posedge clk);
		rst_b <= 1;
		@(negedge clk); chk(codecResetOutN, 0);
		@(posedge clk);
		bus(0, 4'h0, 32'h16); bus(0, 4'h2, 32'hFF); rd(4'h2, 0);
		@(negedge clk); chk(codecResetOutN, 0);
		@(posedge clk); bus(0, 4'h0, 1);
		@(negedge clk); chk(codecResetOutN, 1);
		// Lane 0 disabled: the write must be refused
		@(posedge clk);
		byteenable <= 4'hE;
		bus(0, 4'h0, 0);
		byteenable <= 4'hF;
		@(negedge clk);
		chk(codecResetOutN, 1);
		$display("test reset done");
		@(posedge clk); bus(0, 4'hC, 1); rd(4'hC, 1); bus(0, 4'h8, 3);
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom); en = d[0];
			dly <= i[0] ? 4'h9 : 4'h2; i2sMode <= (i == 5);
			bus(0, 4'h0, {27'h0, en, 1'b0, (i == 5) ? 2'h3 : i[1:0], 1'b1});
			bus(0, 4'h4, {24'h0, d});
			@(negedge clk); chk({txValid, txSecondary, txData}, {1'b1, i % 4 != 0 && i < 5, d});
			for (int k = 0; k < 40 && txValid; k++) @(negedge clk);
			@(posedge clk); rd(4'h0, {26'h0, 1'b1, en, 1'b0, (i == 5) ? 2'h3 : i[1:0], 1'b1});
			@(negedge clk); chk(irq, en);
			@(posedge clk); rd(4'h8, {30'h0, 1'b1, en}); bus(0, 4'h8, 3);
			@(negedge clk); chk(irq, 0);
			@(posedge clk);
			$display("test tx %0d done", i);
		end
		// Mid-run reset must bring the codec reset output back low
		rst_b <= 1'b0;
		@(negedge clk);
		chk(codecResetOutN, 0);
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(4'h0, 32'h20);
		rd(4'h8, 0);
		bus(0, 4'h0, 1);
		@(negedge clk);
		chk(codecResetOutN, 1);
		$display("test mid-run reset done");
		tally_and_finish;
	end
endmodule
